// ==== hdl/gas_regs.sv ====
// Pin fault latches, pin control registers, pin 3 ready signalling and result byte formatting.
// Assumes the serial engine gives one-cycle read/write strobes on core_clk and pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module gas_regs
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire gas_pkg::gas_req_s req,
  output var  logic [7:0]        rdata,
  input  wire logic              control_register_b_wake_en,
  input  wire logic              control_register_b_alert_clr,
  input  wire logic              stuck_wake,
  input  wire logic              adc_ready,
  input  wire logic              other_alert,
  input  wire logic [3:0]        pin_in,
  output var  logic [3:0]        pin_out,
  output var  logic [3:0]        pin_oe_n,
  output var  logic              alert_flag,
  input  wire logic              mode_8bit,
  input  wire logic [11:0]       word_val,
  input  wire logic [23:0]       power_val,
  output var  gas_pkg::gas_fmt_s fmt
);
  import gas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [3:0]        sync1_q;
  logic [3:0]        sync2_q;
  logic [7:0]        alert_en_q;
  logic [7:0]        alert_en_d;
  logic [7:0]        fault_q;
  logic [7:0]        fault_d;
  logic [7:0]        pin_io_q;
  logic [7:0]        pin_io_d;
  logic [7:0]        pin4_q;
  logic [7:0]        pin4_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic              hold_q;
  logic              hold_d;
  logic [PCNT_W-1:0] pcnt_q;
  logic [PCNT_W-1:0] pcnt_d;
  logic [3:0]        oe_n_q;
  logic [3:0]        oe_n_d;
  logic [3:0]        pin_out_q;
  gas_fmt_s          fmt_q;
  gas_fmt_s          fmt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Unmapped addresses read back zero and take no writes
  wire sel_alert_en = req.addr == ADDR_ALERT_EN;
  wire sel_fault    = req.addr == ADDR_FAULT;
  wire sel_state    = req.addr == ADDR_PIN_STATE;
  wire sel_pin_io   = req.addr == ADDR_PIN_IO;
  wire sel_pin4     = req.addr == ADDR_PIN4_CTRL;
  wire wr_alert_en  = req.wr && sel_alert_en;
  wire wr_fault     = req.wr && sel_fault;
  wire wr_pin_io    = req.wr && sel_pin_io;
  wire wr_pin4      = req.wr && sel_pin4;
  wire rd_adc_stat  = req.rd && (req.addr == ADDR_ADC_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Fault set conditions
  // Pins reach the latches only through the second synchroniser stage
  wire [2:0] pol      = pin_io_q[B_POL1:B_POL3];
  wire [2:0] pins_123 = sync2_q[3:1];
  wire [2:0] at_level = ~(pins_123 ^ pol);
  wire       wake_hit = stuck_wake && control_register_b_wake_en;

  // Set vector aligned to the fault register
  wire [7:0] fault_set = {3'h0, wake_hit, at_level, 1'b0};

  // Write zero clears; writing one keeps the bit
  wire [7:0] fault_clr = wr_fault ? (~req.wdata & MASK_FAULT) : 8'h00;

  // Alert generated by an enabled fault of this group or elsewhere
  // Taken from the set condition so the flag is not a cycle behind the fault
  wire own_alert = |(fault_set & alert_en_q & MASK_FAULT);
  wire any_alert = own_alert || other_alert;

  ////////////////////////////////////////////////////////////////////////////
  // Pin 3 ready signalling
  wire [1:0] p3_mode = pin_io_q[B_P3CFG_HI:B_P3CFG_LO];
  wire       pulse_on = pcnt_q != '0;

  // Pulse width for the selected mode
  wire [PCNT_W-1:0] pulse_len = (p3_mode == P3_LONG) ? PCNT_W'(PULSE_LONG_CYC) : PCNT_W'(PULSE_SHORT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Alert enable register
  always_comb
  begin
    alert_en_d = alert_en_q;
    if (wr_alert_en)
    begin
      alert_en_d = req.wdata & MASK_ALERT_EN;
    end
  end

  // Fault latches, set wins over the clear
  // A zero written while the pin is still at level leaves the bit set
  always_comb
  begin
    fault_d = ((fault_q & ~fault_clr) | fault_set) & MASK_FAULT;
  end

  // Pin I/O control register
  always_comb
  begin
    pin_io_d = pin_io_q;
    if (wr_pin_io)
    begin
      pin_io_d = req.wdata;
    end
  end

  // Pin 4 control and the alert flag
  always_comb
  begin
    pin4_d = pin4_q;
    if (wr_pin4)
    begin
      pin4_d[B_OUT4] = req.wdata[B_OUT4];
      if (!req.wdata[B_ALERT_FLAG])
      begin
        pin4_d[B_ALERT_FLAG] = 1'b0;
      end
    end
    if (control_register_b_alert_clr)
    begin
      pin4_d[B_ALERT_FLAG] = 1'b0;
    end
    if (any_alert)
    begin
      pin4_d[B_ALERT_FLAG] = 1'b1;
    end
    pin4_d = pin4_d & MASK_PIN4;
  end

  // Hold-low latch and pulse timer for pin 3
  // A result during a running pulse is dropped, never stretching it
  // Leaving hold mode drops its latch and leaving both pulse modes drops the timer, so no stale pulse follows
  always_comb
  begin
    hold_d = hold_q;
    pcnt_d = pcnt_q;
    if (p3_mode != P3_HOLD)
    begin
      hold_d = 1'b0;
    end
    else
    begin
      if (rd_adc_stat)
      begin
        hold_d = 1'b0;
      end
      if (adc_ready)
      begin
        hold_d = 1'b1;
      end
    end
    if ((p3_mode == P3_LONG) || (p3_mode == P3_SHORT))
    begin
      if (pulse_on)
      begin
        pcnt_d = pcnt_q - PCNT_W'(1);
      end
      else if (adc_ready)
      begin
        pcnt_d = pulse_len;
      end
    end
    else
    begin
      pcnt_d = '0;
    end
  end

  // Pin drivers, low enable means pulling low
  // Mode bits pick what pulls pin 3; pins 1, 2 and 4 follow their bits
  always_comb
  begin
    oe_n_d[3] = ~pin_io_q[B_OUT1];
    oe_n_d[2] = ~pin_io_q[B_OUT2];
    oe_n_d[0] = ~pin4_q[B_OUT4];
    case (p3_mode)
      P3_GPIO:  oe_n_d[1] = ~pin_io_q[B_OUT3];
      P3_SHORT: oe_n_d[1] = ~pulse_on;
      P3_LONG:  oe_n_d[1] = ~pulse_on;
      P3_HOLD:  oe_n_d[1] = ~hold_q;
      default:  oe_n_d[1] = 1'b1;
    endcase
  end

  // Read data mux
  // Data holds between reads so the host may take it late
  always_comb
  begin
    rdata_d = rdata_q;
    if (req.rd)
    begin
      rdata_d = RD_UNMAPPED;
      if (sel_alert_en)
      begin
        rdata_d = alert_en_q;
      end
      if (sel_fault)
      begin
        rdata_d = fault_q;
      end
      if (sel_state)
      begin
        rdata_d = {4'h0, sync2_q};
      end
      if (sel_pin_io)
      begin
        rdata_d = pin_io_q;
      end
      if (sel_pin4)
      begin
        rdata_d = pin4_q;
      end
    end
  end

  // Result byte layout
  // Eight-bit mode keeps the low bits of the raw value
  always_comb
  begin
    if (mode_8bit)
    begin
      fmt_d.pair   = {word_val[7:0], 8'h00};
      fmt_d.triple = {power_val[15:0], 8'h00};
    end
    else
    begin
      fmt_d.pair   = {word_val, 4'h0};
      fmt_d.triple = power_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  // Reset high, the idle level of the pulled-up pins
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Register state
  // Pin I/O resets with pin 3 pulled low and alerting on high
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      alert_en_q <= RST_ALERT_EN;
      fault_q    <= RST_FAULT;
      pin_io_q   <= RST_PIN_IO;
      pin4_q     <= RST_PIN4;
    end
    else
    begin
      alert_en_q <= alert_en_d;
      fault_q    <= fault_d;
      pin_io_q   <= pin_io_d;
      pin4_q     <= pin4_d;
    end
  end

  // Pin 3 timing state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hold_q <= 1'b0;
      pcnt_q <= '0;
    end
    else
    begin
      hold_q <= hold_d;
      pcnt_q <= pcnt_d;
    end
  end

  // Output flops
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      oe_n_q  <= 4'hf;
      rdata_q <= 8'h00;
      fmt_q   <= '0;
      pin_out_q <= 4'h0;
    end
    else
    begin
      oe_n_q  <= oe_n_d;
      rdata_q <= rdata_d;
      fmt_q   <= fmt_d;
      pin_out_q <= 4'h0;  // Open-drain data stays zero; enables do the work
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata      = rdata_q;
  assign pin_oe_n   = oe_n_q;
  assign pin_out    = pin_out_q;
  assign alert_flag = pin4_q[B_ALERT_FLAG];
  assign fmt        = fmt_q;

endmodule : gas_regs

`default_nettype wire

// ==== hdl/gas_pkg.sv ====
// Constants, register map and carrier types for the pin and alert block.
// Assumes a single 20 MHz core clock and a byte-wide register port.
package gas_pkg;

  // Clock period and pulse widths
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_LONG_US = 128;
  localparam int unsigned PULSE_SHORT_US = 16;
  localparam int unsigned PULSE_LONG_CYC = (PULSE_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_SHORT_CYC = (PULSE_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PCNT_W = 12;

  // Register offsets
  localparam logic [7:0] ADDR_ADC_STATUS = 8'h32;
  localparam logic [7:0] ADDR_ALERT_EN = 8'h93;
  localparam logic [7:0] ADDR_FAULT = 8'h94;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h95;
  localparam logic [7:0] ADDR_PIN_IO = 8'h96;
  localparam logic [7:0] ADDR_PIN4_CTRL = 8'h97;

  // Field positions
  localparam int unsigned B_WAKE = 4;
  localparam int unsigned B_IN1 = 3;
  localparam int unsigned B_IN3 = 1;
  localparam int unsigned B_OUT1 = 7;
  localparam int unsigned B_OUT2 = 6;
  localparam int unsigned B_P3CFG_HI = 5;
  localparam int unsigned B_P3CFG_LO = 4;
  localparam int unsigned B_POL1 = 3;
  localparam int unsigned B_POL3 = 1;
  localparam int unsigned B_OUT3 = 0;
  localparam int unsigned B_ALERT_FLAG = 7;
  localparam int unsigned B_OUT4 = 6;

  // Writable masks (reserved bits excluded)
  localparam logic [7:0] MASK_ALERT_EN = 8'hde;
  localparam logic [7:0] MASK_FAULT = 8'h1e;
  localparam logic [7:0] MASK_PIN4 = 8'hc0;

  // Reset values
  localparam logic [7:0] RST_ALERT_EN = 8'h00;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RST_PIN_IO = 8'h03;
  localparam logic [7:0] RST_PIN4 = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Pin 3 signalling modes
  localparam logic [1:0] P3_GPIO = 2'b00;
  localparam logic [1:0] P3_SHORT = 2'b01;
  localparam logic [1:0] P3_LONG = 2'b10;
  localparam logic [1:0] P3_HOLD = 2'b11;

  // Register access request from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gas_req_s;

  // Formatted result bytes, most significant byte first
  typedef struct packed {
    logic [15:0] pair;
    logic [23:0] triple;
  } gas_fmt_s;

endpackage : gas_pkg

// ==== verif/gas_host.sv ====
// Register host model for the pin and alert block.
// Assumes requests change on the falling edge of core_clk.
`timescale 1ns/1ns
`default_nettype none
module gas_host
(
  input  wire logic              core_clk,
  output var  gas_pkg::gas_req_s req,
  input  wire logic [7:0]        rdata
);
  import gas_pkg::*;
  initial req = '0;

  // One-cycle write strobe; a zero clears latched bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    req = '0;
  endtask : wr

  // One-cycle read strobe, data taken after the answer edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    req = '0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd
endmodule : gas_host
`default_nettype wire

// ==== verif/gas_regs_asserts.sv ====
// Port checks for the pin and alert register block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module gas_regs_asserts
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire gas_pkg::gas_req_s req,
  input wire logic [7:0]        rdata,
  input wire logic              control_register_b_wake_en,
  input wire logic              control_register_b_alert_clr,
  input wire logic              stuck_wake,
  input wire logic              adc_ready,
  input wire logic              other_alert,
  input wire logic [3:0]        pin_in,
  input wire logic [3:0]        pin_out,
  input wire logic [3:0]        pin_oe_n,
  input wire logic              alert_flag,
  input wire logic              mode_8bit,
  input wire logic [11:0]       word_val,
  input wire logic [23:0]       power_val,
  input wire gas_pkg::gas_fmt_s fmt
);
  import gas_pkg::*;
  logic [7:0]  io_q;
  logic [11:0] low_q;
  // Write decode of the pin I/O and pin 4 registers and reserved-bit mask of the fault, pin state and pin 4 registers
  wire logic       wr_io = req.wr && req.addr == ADDR_PIN_IO;
  wire logic       wr_p4 = req.wr && req.addr == ADDR_PIN4_CTRL;
  wire logic [7:0] rsv_m = req.addr == ADDR_FAULT ? ~MASK_FAULT : req.addr == ADDR_PIN_STATE ? 8'hf0 :
                           req.addr == ADDR_PIN4_CTRL ? ~MASK_PIN4 : 8'h00;
  // Pin 3 mode shadow and low-time counter
  always_ff @(posedge core_clk)
  begin
    io_q  <= srst ? RST_PIN_IO : (wr_io ? req.wdata : io_q);
    low_q <= pin_oe_n[1] ? 12'h000 : low_q + 12'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_ready;
    adc_ready && io_q[5:4] == P3_HOLD;
  endsequence
  sequence s_ack;
    req.rd && req.addr == ADDR_ADC_STATUS && !adc_ready && io_q[5:4] == P3_HOLD;
  endsequence
  AST_RST_IO: assert property ($fell(srst) |=> pin_oe_n == 4'b1101)
    else $error("pin drive wrong after reset");
  AST_RSV: assert property (req.rd |=> (rdata & $past(rsv_m)) == 8'h00)
    else $error("reserved bits read nonzero");
  AST_OUT12: assert property (wr_io ##1 !wr_io |-> ##1 pin_oe_n[3:2] == ~$past(req.wdata[7:6], 2))
    else $error("pins 1 2 drive mismatch");
  AST_HOLD_SET: assert property (s_ready |-> ##2 !pin_oe_n[1])
    else $error("pin 3 not held low");
  AST_HOLD_REL: assert property (s_ack |-> ##2 pin_oe_n[1])
    else $error("pin 3 not released");
  AST_PULSE_LEN: assert property ($rose(pin_oe_n[1]) && io_q[5] != io_q[4] |->
    low_q == (io_q[5] ? PULSE_LONG_CYC : PULSE_SHORT_CYC)) else $error("pin 3 pulse length wrong");
  AST_FLAG: assert property (other_alert |-> ##[1:2] alert_flag)
    else $error("alert flag not set");
  AST_FMT12: assert property (!mode_8bit |=> fmt == {$past(word_val), 4'h0, $past(power_val)})
    else $error("wide layout wrong");
  AST_FMT8: assert property (mode_8bit |=>
    fmt == {$past(word_val[7:0]), 8'h00, $past(power_val[15:0]), 8'h00}) else $error("narrow layout wrong");
  AST_PIN4_OUT: assert property (wr_p4 ##1 !wr_p4 |-> ##1 pin_oe_n[0] == ~$past(req.wdata[B_OUT4], 2))
    else $error("pin 4 drive mismatch");
  AST_PIN_STATE: assert property (req.rd && req.addr == ADDR_PIN_STATE |=> rdata[3:0] == $past(pin_in, 3))
    else $error("pin state readback wrong");
endmodule : gas_regs_asserts
bind gas_regs gas_regs_asserts u_chk (.core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata),
  .control_register_b_wake_en(control_register_b_wake_en), .control_register_b_alert_clr(control_register_b_alert_clr), .stuck_wake(stuck_wake),
  .adc_ready(adc_ready), .other_alert(other_alert), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .alert_flag(alert_flag), .mode_8bit(mode_8bit), .word_val(word_val),
  .power_val(power_val), .fmt(fmt));
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the pin and alert register block.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gas_pkg::*;
  typedef struct packed {logic m8; logic [11:0] w; logic [23:0] p; logic [39:0] e;} gas_row_s;
  localparam gas_row_s ROWS [4] = '{'{1'b0, 12'habc, 24'h123456, 40'habc0123456},
    '{1'b1, 12'habc, 24'h123456, 40'hbc00345600}, '{1'b0, 12'hfff, 24'h800001, 40'hfff0800001},
    '{1'b1, 12'h001, 24'h00ff80, 40'h0100ff8000}};
  logic            core_clk = 1'b0;
  logic            srst = 1'b1;
  logic            wake_en = 1'b0, aclr = 1'b0, swake = 1'b0, adc = 1'b0, oth = 1'b0, m8 = 1'b0, flag;
  logic [11:0]     wv = '0;
  logic [23:0]     pv = '0;
  logic [3:0]      ext_low = '0, oe_n, pout;
  logic [7:0]      rdata, d;
  gas_fmt_s        fmt;
  gas_req_s        req;
  int              error_cnt = 0, samples_checked = 0, cyc = 0, n;
  // Open-drain pins with pull-ups
  wire logic [3:0] pin_w = ~ext_low & (oe_n | pout);

  gas_host host (.core_clk(core_clk), .req(req), .rdata(rdata));
  gas_regs dut (.core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata), .control_register_b_wake_en(wake_en),
    .control_register_b_alert_clr(aclr), .stuck_wake(swake), .adc_ready(adc), .other_alert(oth), .pin_in(pin_w),
    .pin_out(pout), .pin_oe_n(oe_n), .alert_flag(flag), .mode_8bit(m8), .word_val(wv),
    .power_val(pv), .fmt(fmt));

  initial forever #25 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(40'(d), 40'(e));
  endtask : rchk
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse
  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    foreach (ROWS[i])
    begin
      {m8, wv, pv} = {ROWS[i].m8, ROWS[i].w, ROWS[i].p};
      @(negedge core_clk);
      chk(fmt, ROWS[i].e);
    end
    host.wr(ADDR_FAULT, 8'h00);
    rchk(ADDR_ALERT_EN, 8'h00);
    rchk(ADDR_FAULT, 8'h00);
    rchk(ADDR_PIN_IO, 8'h03);
    rchk(ADDR_PIN_STATE, 8'h0d);
    rchk(8'h50, 8'h00);
    host.wr(ADDR_PIN4_CTRL, 8'h7f);
    repeat (3) @(negedge core_clk);
    rchk(ADDR_PIN4_CTRL, 8'h40);
    rchk(ADDR_PIN_STATE, 8'h0c);
    host.wr(ADDR_PIN4_CTRL, 8'h00);
    host.wr(ADDR_PIN_IO, 8'hc2);
    repeat (4) @(negedge core_clk);
    rchk(ADDR_PIN_STATE, 8'h03);
    rchk(ADDR_FAULT, 8'h0e);
    host.wr(ADDR_PIN_IO, 8'h00);
    repeat (4) @(negedge core_clk);
    rchk(ADDR_FAULT, 8'h0e);
    host.wr(ADDR_FAULT, 8'h00);
    rchk(ADDR_FAULT, 8'h00);
    rchk(ADDR_PIN4_CTRL, 8'h00);
    host.wr(ADDR_ALERT_EN, 8'h08);
    ext_low[3] = 1'b1;
    repeat (5) @(negedge core_clk);
    ext_low[3] = 1'b0;
    rchk(ADDR_PIN4_CTRL, 8'h80);
    chk(40'(flag), 40'h1);
    host.wr(ADDR_FAULT, 8'h00);
    pulse(aclr);
    rchk(ADDR_PIN4_CTRL, 8'h00);
    pulse(oth);
    rchk(ADDR_PIN4_CTRL, 8'h80);
    host.wr(ADDR_PIN4_CTRL, 8'h00);
    rchk(ADDR_PIN4_CTRL, 8'h00);
    pulse(swake);
    rchk(ADDR_FAULT, 8'h00);
    wake_en = 1'b1;
    pulse(swake);
    rchk(ADDR_FAULT, 8'h10);
    for (int m = 1; m < 3; m++)
    begin
      host.wr(ADDR_PIN_IO, {2'b00, 2'(m), 4'h0});
      pulse(adc);
      n = 0;
      repeat (2600)
      begin
        @(negedge core_clk);
        n += int'(oe_n[1] === 1'b0);
      end
      chk(40'(n), 40'(m == 1 ? PULSE_SHORT_CYC : PULSE_LONG_CYC));
    end
    host.wr(ADDR_PIN_IO, 8'h30);
    pulse(adc);
    repeat (20) @(negedge core_clk);
    chk(40'(oe_n[1]), 40'h0);
    host.rd(ADDR_ADC_STATUS, d);
    @(negedge core_clk);
    chk(40'(oe_n[1]), 40'h1);
    // Reset in mid-run restores the defaults; pin 3 is pulled low again after release
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(40'(oe_n), 40'hd);
    rchk(ADDR_ALERT_EN, 8'h00);
    rchk(ADDR_FAULT, 8'h02);
    rchk(ADDR_PIN4_CTRL, 8'h00);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
